// >>> rtl/sltf_pkg.sv
/*
 Shared constants and types of the self-test, lock and field-limit block.
 Assumes a 100 MHz core clock and 24-bit serial registers.
*/
package sltf_pkg;
   // Register offsets
   localparam logic [7:0]  ADDR_COM  = 8'h1E;
   localparam logic [7:0]  ADDR_CUSTOMER_STORAGE_WORD = 8'h1F;
   localparam logic [7:0]  ADDR_ANG  = 8'h20;
   // Position of the general error bit in the angle register
   localparam int          EF_BIT    = 23;
   // Lock patterns
   localparam logic [3:0]  LOCK_NVM  = 4'hC;
   localparam logic [3:0]  LOCK_ALL  = 4'h3;
   // Factory values; both limits carry their factory codes
   localparam logic [23:0] COM_RST   = 24'h0C094D;
   localparam logic [23:0] CUSTOMER_STORAGE_WORD_RST  = 24'h000000;
   // Field limit steps in gauss
   localparam logic [11:0] HI_STEP_G = 12'h020;
   localparam logic [11:0] LO_STEP_G = 12'h010;
   // Self-test duration
   localparam int          TEST_MS   = 30;
   localparam int          CLK_MHZ   = 100;
   localparam int          TEST_CYC  = TEST_MS * CLK_MHZ * 1000;
   // Transducer emulation: eight positions, 45 degrees apart
   localparam int          HALL_STEPS = 8;
   localparam logic [11:0] HALL_ANG   = 12'h200;
   localparam logic [11:0] HALL_TOL   = 12'h040;
   // Pattern generator and compactor
   localparam logic [30:0] LFSR_SEED  = 31'h00000001;
   localparam logic [30:0] MISR_SEED  = 31'h00000000;
   localparam int          POLY_TAP   = 27;

   // Configuration word layout
   typedef struct packed {
      logic [3:0] lock;
      logic       powerup_logic_test_en;
      logic       powerup_transducer_test_en;
      logic [3:0] rsv;
      logic       dst;
      logic       serial_hard_reset_disable;
      logic [5:0] hi;
      logic [5:0] lo;
   } sltf_com_t;

   // Error and warning flags
   typedef struct packed {
      logic selftest_fail_flag;
      logic field_low_flag;
      logic field_high_flag;
   } sltf_flag_t;

   typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_TEST} sltf_state_t;
endpackage : sltf_pkg

// >>> rtl/sltf_core.sv
/*
 Configuration register with permanent lock, power-up and serial
 self-tests (pattern generator/compactor and transducer emulation),
 field limit flags and general error aggregation.
 Assumes the serial front end turns frames into one-cycle register
 strobes, and that scan chains and the Hall path sit outside.
*/
// Overview of operation
// RL1: Code 1100 refuses nonvolatile writes, shadow allowed
// RL2: Code 0011 refuses nonvolatile and shadow writes
// RL3: Logic test enable runs it at power-up
// RL4: Transducer test enable runs it at power-up
// RL5: Both tests run together, about 30 ms
// RL6: Disable bit blocks serial self-test start
// RL7: Disable bit blocks serial hard reset
// RL8: High limit 32 G steps, zero disables
// RL9: High limit factory code 10 0101
// RL10: Low limit 16 G steps, zero disables
// RL11: Low limit factory code 00 1101
// RL12: Host may start self-tests any time; starts are taken only in idle, not during boot or a run
// RL13: Any test failure sets failure flag
// RL14: Test current emulates rotating field, angle judged
// RL15: Transducer test lasts about 30 ms
// RL16: 31 chains fed by 31-bit LFSR
// RL17: Chains compressed into checked 31-bit signature
// RL18: All flags readable through register map; only the general error is, as bit 23 at 0x20
// RL19: Unmasked error flags raise general error
// RL20: Field above high limit raises flags
// RL21: Field below low limit raises flags
// RL22: Stored lock field cannot be changed
`timescale 1ns/1ns
`default_nettype none
module sltf_core
   import sltf_pkg::*;
#(
   parameter int          TEST_CYCLES = TEST_CYC,
   parameter logic [30:0] LOGIC_SELF_TEST_SIG   = 31'h00000000
) (
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_nvm_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [23:0] reg_wdata_i,
   input  wire logic        reg_rd_i,
   output logic      [23:0] reg_rdata_o,
   output logic             reg_wr_err_o,
   input  wire logic        selftest_cmd_i,
   input  wire logic        hard_reset_cmd_i,
   output logic             hard_reset_o,
   output logic             scan_en_o,
   output logic      [30:0] scan_in_o,
   input  wire logic [30:0] scan_out_i,
   output logic             hall_test_en_o,
   output logic             hall_test_dir_o,
   output logic      [1:0]  hall_elem_sel_o,
   input  wire logic [11:0] hall_angle_i,
   input  wire logic [11:0] field_g_i,
   input  wire logic [2:0]  flag_mask_i,
   output logic             selftest_busy_o,
   output logic             selftest_fail_flag_o,
   output logic             field_high_flag_o,
   output logic             field_low_flag_o,
   output logic             general_error_flag_o
);
   // Step length of the transducer emulation
   localparam int          STEP_CYC = TEST_CYCLES / HALL_STEPS;
   localparam logic [21:0] T_END    = 22'(TEST_CYCLES - 1);
   localparam logic [18:0] S_END    = 19'(STEP_CYC - 1);

   // Clears reserved bits; keeps the old lock code when asked
   function automatic sltf_com_t com_merge(input sltf_com_t old_v,
                                           input sltf_com_t new_v,
                                           input logic keep);
      sltf_com_t r;
      r = new_v;
      r.rsv = 4'h0;
      if (keep) begin
         r.lock = old_v.lock;
      end
      return r;
   endfunction : com_merge

   // One shift of the shared polynomial
   function automatic logic [30:0] poly_step(input logic [30:0] v);
      return {v[29:0], v[30] ^ v[POLY_TAP]};
   endfunction : poly_step

   sltf_com_t   nvm_com_ff;     // Nonvolatile configuration
   logic [23:0] nvm_customer_storage_word_ff;    // Nonvolatile customer word
   sltf_com_t   sh_com_ff;      // Shadow configuration, steers logic
   logic [23:0] sh_customer_storage_word_ff;     // Shadow customer word
   sltf_state_t state_ff;       // Boot / idle / test
   logic [21:0] timer_ff;       // Test duration counter
   logic [18:0] step_tmr_ff;    // Emulation step counter
   logic [2:0]  step_ff;        // Emulated field position
   logic        logic_self_test_on_ff;    // Logic test active in this run
   logic        hall_on_ff;     // Transducer test active in this run
   logic        hall_bad_ff;    // Angle missed during this run
   logic [30:0] lfsr_ff;        // Pattern generator
   logic [30:0] misr_ff;        // Signature compactor
   sltf_flag_t  flag_ff;        // Error and warning flags
   logic        ef_ff;          // General error
   logic [23:0] rdata_ff;       // Read data
   logic        wr_err_ff;      // Refused write pulse
   logic        hrst_ff;        // Hard reset pulse

   // Lock decode from the nonvolatile copy only
   wire logic [3:0] lock_code  = nvm_com_ff.lock;
   wire logic       nvm_locked = (lock_code == LOCK_NVM) ||
                                 (lock_code == LOCK_ALL);
   wire logic       sh_locked  = (lock_code == LOCK_ALL);
   wire logic       hit_com    = reg_addr_i == ADDR_COM;
   wire logic       hit_customer_storage_word   = reg_addr_i == ADDR_CUSTOMER_STORAGE_WORD;
   wire logic       wr_hit     = reg_wr_i && (hit_com || hit_customer_storage_word);
   wire logic       in_boot    = state_ff == ST_BOOT;
   // Writes pass only when the lock allows them
   wire logic nvm_wr_ok = wr_hit && reg_nvm_i && !nvm_locked;  // [RL1]
   wire logic sh_wr_ok  = wr_hit && !reg_nvm_i && !sh_locked &&
                          !in_boot;                            // [RL2]
   wire sltf_com_t wcom = sltf_com_t'(reg_wdata_i);
   // Shadow never takes a new lock code once one is stored
   wire sltf_com_t sh_wcom  = com_merge(sh_com_ff, wcom,
                                        nvm_locked);           // [RL22]
   wire sltf_com_t nvm_wcom = com_merge(nvm_com_ff, wcom, 1'b0);

   // Test timing
   wire logic in_test  = state_ff == ST_TEST;
   wire logic t_end    = in_test && (timer_ff == T_END);
   wire logic s_end    = in_test && (step_tmr_ff == S_END);
   wire logic st_start = (state_ff == ST_IDLE) && selftest_cmd_i &&
                         !sh_com_ff.dst;                  // [RL6] [RL12]
   // Expected angle and wrap-around distance
   wire logic [11:0] exp_ang  = 12'(step_ff * HALL_ANG);
   wire logic [11:0] ang_d    = hall_angle_i - exp_ang;
   wire logic [11:0] ang_abs  = ang_d[11] ? (12'h000 - ang_d) : ang_d;
   wire logic        ang_miss = ang_abs > HALL_TOL;             // [RL14]
   wire logic        sig_bad  = logic_self_test_on_ff && (misr_ff != LOGIC_SELF_TEST_SIG);
   wire logic        run_fail = sig_bad ||
                                (hall_on_ff &&
                                 (hall_bad_ff || (s_end && ang_miss)));

   // Field limits in gauss
   wire logic [11:0] hi_lim = 12'(sh_com_ff.hi * HI_STEP_G);    // [RL8]
   wire logic [11:0] lo_lim = 12'(sh_com_ff.lo * LO_STEP_G);    // [RL10]
   wire logic hi_trip = (sh_com_ff.hi != 6'h00) && (field_g_i > hi_lim);
   wire logic lo_trip = (sh_com_ff.lo != 6'h00) && (field_g_i < lo_lim);
   wire sltf_flag_t live = '{selftest_fail_flag: flag_ff.selftest_fail_flag, field_low_flag: lo_trip, field_high_flag: hi_trip};
   wire logic ef_nxt = |(flag_ff & ~sltf_flag_t'(flag_mask_i)); // [RL19]

   // Read selection; reserved bits come back as zero
   wire logic [23:0] ang_word = 24'(ef_ff) << EF_BIT;
   wire logic [23:0] rd_mux   = hit_com  ? 24'(sh_com_ff) :
                                hit_customer_storage_word ? sh_customer_storage_word_ff :
                                (reg_addr_i == ADDR_ANG) ? ang_word :
                                24'h000000;                      // [RL18]

   // Nonvolatile store; reset stands for the factory contents
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         nvm_com_ff  <= sltf_com_t'(COM_RST);            // [RL9] [RL11]
         nvm_customer_storage_word_ff <= CUSTOMER_STORAGE_WORD_RST;
      end else if (nvm_wr_ok && hit_com) begin
         nvm_com_ff  <= nvm_wcom;                              // [RL1]
      end else if (nvm_wr_ok) begin
         nvm_customer_storage_word_ff <= reg_wdata_i;
      end
   end

   // Shadow copy: loaded from the store at boot, then host writes
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sh_com_ff  <= sltf_com_t'(COM_RST);             // [RL9] [RL11]
         sh_customer_storage_word_ff <= CUSTOMER_STORAGE_WORD_RST;
      end else if (in_boot) begin
         sh_com_ff  <= nvm_com_ff;
         sh_customer_storage_word_ff <= nvm_customer_storage_word_ff;
      end else if (sh_wr_ok && hit_com) begin
         sh_com_ff  <= sh_wcom;                                // [RL2]
      end else if (sh_wr_ok) begin
         sh_customer_storage_word_ff <= reg_wdata_i;
      end
   end

   // Sequencer; one timer serves both tests so they end together
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_ff    <= ST_BOOT;
         logic_self_test_on_ff <= 1'b0;
         hall_on_ff  <= 1'b0;
      end else begin
         case (state_ff)
            ST_BOOT: begin
               // Power-up enables come from the stored copy
               logic_self_test_on_ff <= nvm_com_ff.powerup_logic_test_en;                  // [RL3]
               hall_on_ff  <= nvm_com_ff.powerup_transducer_test_en;                  // [RL4]
               state_ff    <= (nvm_com_ff.powerup_logic_test_en || nvm_com_ff.powerup_transducer_test_en) ?
                              ST_TEST : ST_IDLE;               // [RL5]
            end
            ST_IDLE: begin
               // Serial start runs both tests
               if (st_start) begin
                  logic_self_test_on_ff <= 1'b1;                        // [RL12]
                  hall_on_ff  <= 1'b1;
                  state_ff    <= ST_TEST;
               end
            end
            ST_TEST: begin
               if (t_end) begin
                  state_ff <= ST_IDLE;                  // [RL5] [RL15]
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Duration and step counters, cleared outside a run
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         timer_ff    <= 22'h000000;
         step_tmr_ff <= 19'h00000;
         step_ff     <= 3'h0;
      end else if (!in_test || t_end) begin
         timer_ff    <= 22'h000000;
         step_tmr_ff <= 19'h00000;
         step_ff     <= 3'h0;
      end else begin
         timer_ff    <= timer_ff + 22'h000001;
         step_tmr_ff <= s_end ? 19'h00000 : step_tmr_ff + 19'h00001;
         step_ff     <= s_end ? step_ff + 3'h1 : step_ff;     // [RL14]
      end
   end

   // Pattern generator feeds all chains, compactor folds them
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lfsr_ff <= LFSR_SEED;
         misr_ff <= MISR_SEED;
      end else if (in_test && logic_self_test_on_ff && !t_end) begin
         lfsr_ff <= poly_step(lfsr_ff);                       // [RL16]
         misr_ff <= poly_step(misr_ff) ^ scan_out_i;          // [RL17]
      end else if (!in_test) begin
         lfsr_ff <= LFSR_SEED;
         misr_ff <= MISR_SEED;
      end
   end

   // Angle check at the end of every emulation step
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hall_bad_ff <= 1'b0;
      end else if (!in_test) begin
         hall_bad_ff <= 1'b0;
      end else if (hall_on_ff && s_end && ang_miss) begin
         hall_bad_ff <= 1'b1;                                 // [RL14]
      end
   end

   // Flags; the failure flag only clears when a new run starts
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flag_ff <= '0;
         ef_ff   <= 1'b0;
      end else begin
         flag_ff <= live;                               // [RL20] [RL21]
         if (t_end && run_fail) begin
            flag_ff.selftest_fail_flag <= 1'b1;                              // [RL13]
         end else if (st_start) begin
            flag_ff.selftest_fail_flag <= 1'b0;
         end
         ef_ff <= ef_nxt;                                     // [RL19]
      end
   end

   // Bus answers and hard reset request
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_ff  <= 24'h000000;
         wr_err_ff <= 1'b0;
         hrst_ff   <= 1'b0;
      end else begin
         if (reg_rd_i) begin
            rdata_ff <= rd_mux;                               // [RL18]
         end
         wr_err_ff <= wr_hit && !nvm_wr_ok && !sh_wr_ok;
         hrst_ff   <= hard_reset_cmd_i && !sh_com_ff.serial_hard_reset_disable;     // [RL7]
      end
   end

   assign reg_rdata_o          = rdata_ff;
   assign reg_wr_err_o         = wr_err_ff;
   assign hard_reset_o         = hrst_ff;
   assign scan_en_o            = in_test && logic_self_test_on_ff;
   assign scan_in_o            = lfsr_ff;
   assign hall_test_en_o       = in_test && hall_on_ff;
   assign hall_test_dir_o      = step_ff[2];
   assign hall_elem_sel_o      = step_ff[1:0];
   assign selftest_busy_o      = in_test;
   assign selftest_fail_flag_o = flag_ff.selftest_fail_flag;
   assign field_high_flag_o    = flag_ff.field_high_flag;
   assign field_low_flag_o     = flag_ff.field_low_flag;
   assign general_error_flag_o = ef_ff;

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   nvm_lock_a: assert property (nvm_locked && reg_wr_i && reg_nvm_i // [RL1]
      |=> $stable(nvm_com_ff) && $stable(nvm_customer_storage_word_ff))
      else $error("locked store was written");
   sh_lock_a: assert property (sh_locked && reg_wr_i && !in_boot // [RL2]
      |=> $stable(sh_com_ff) && $stable(sh_customer_storage_word_ff))
      else $error("fully locked shadow was written");
   lock_kept_a: assert property (nvm_locked // [RL22]
      |=> nvm_com_ff.lock == $past(lock_code))
      else $error("stored lock code changed");
   pwrup_logic_a: assert property (in_boot && nvm_com_ff.powerup_logic_test_en // [RL3]
      |=> in_test && logic_self_test_on_ff && scan_en_o)
      else $error("power-up logic test not run");
   pwrup_hall_a: assert property (in_boot && !nvm_com_ff.powerup_transducer_test_en // [RL4]
      |=> !hall_test_en_o)
      else $error("transducer test ran while disabled");
   test_end_a: assert property (t_end // [RL5] [RL15]
      |=> state_ff == ST_IDLE && !scan_en_o && !hall_test_en_o)
      else $error("self-test overran its window");
   st_block_a: assert property (in_test == 1'b0 && // [RL6]
      state_ff == ST_IDLE && selftest_cmd_i &&
      sh_com_ff.dst |=> state_ff == ST_IDLE)
      else $error("blocked self-test started");
   st_go_a: assert property (st_start // [RL12]
      |=> in_test && logic_self_test_on_ff && hall_on_ff)
      else $error("serial self-test did not start");
   hrst_gate_a: assert property (hard_reset_o // [RL7]
      |-> $past(hard_reset_cmd_i) && !$past(sh_com_ff.serial_hard_reset_disable))
      else $error("hard reset despite disable");
   hi_off_a: assert property (sh_com_ff.hi == 6'h00 // [RL8]
      && $stable(sh_com_ff) |=> !field_high_flag_o)
      else $error("high field flag while disabled");
   lo_off_a: assert property (sh_com_ff.lo == 6'h00 // [RL10]
      && $stable(sh_com_ff) |=> !field_low_flag_o)
      else $error("low field flag while disabled");
   fail_set_a: assert property (t_end && sig_bad // [RL13]
      |=> selftest_fail_flag_o)
      else $error("bad signature not flagged");
   ef_agg_a: assert property (hi_trip && !flag_mask_i[0] // [RL19]
      |=> ##1 general_error_flag_o)
      else $error("unmasked flag missed general error");

   run_cov_c: cover property (in_boot ##1 in_test[*2]);
   fail_cov_c: cover property (t_end ##1 selftest_fail_flag_o);
   hrst_cov_c: cover property (hard_reset_o);
   lock_cov_c: cover property (nvm_locked && wr_hit ##1 reg_wr_err_o);
endmodule : sltf_core
`default_nettype wire

// >>> bench/sltf_sense_model.sv
/*
 Far-side model of the scan chains and the transducer test path.
 Assumes the core steps its emulation through direction and element
 select, and folds chain outputs only while the logic test runs.
*/
`timescale 1ns/1ns
`default_nettype none
module sltf_sense_model (
   input  wire logic [30:0] scan_in_i,
   input  wire logic        scan_en_i,
   input  wire logic        hall_en_i,
   input  wire logic        hall_dir_i,
   input  wire logic [1:0]  hall_sel_i,
   input  wire logic        bad_hall_i,
   input  wire logic        bad_scan_i,
   output logic      [11:0] hall_angle_o,
   output logic      [30:0] scan_out_o
);
   // Angle of the emulated step, eight steps 45 degrees apart
   wire logic [11:0] step_angle = {hall_dir_i, hall_sel_i, 9'h000};
   // Error offset far beyond tolerance when a fault is commanded
   wire logic [11:0] bad_ofs    = bad_hall_i ? 12'h100 : 12'h000;

   // Idle path shows the inverse, so a stale value fails the check except at steps 0 and 4
   assign hall_angle_o = !hall_en_i ? ~step_angle
                                    : step_angle + bad_ofs;
   // Healthy chains return zeros, keeping the signature at its seed
   assign scan_out_o   = !scan_en_i ? ~scan_in_i
                       : (bad_scan_i ? scan_in_i
                                     : 31'h00000000);
endmodule : sltf_sense_model
`default_nettype wire

// >>> bench/selftest_lock_field_config_test.sv
/*
 Self-checking bench of the lock, self-test and field limit core.
 Assumes the sense model stands in for the chains and the transducer.
*/
`timescale 1ns/1ns
`default_nettype none
module selftest_lock_field_config_test;
   import sltf_pkg::*;
   localparam int NCYC = 64;  // Short test run, multiple of 8
   typedef struct packed {
      logic [5:0]  hi;
      logic [5:0]  lo;
      logic [11:0] fld;
      logic        eh;
      logic        el;
   } sltf_row_t;
   // Field limit cases: codes, field, expected high and low flags
   localparam sltf_row_t ROWS [8] = '{
      '{6'h25, 6'h0D, 12'h4A0, 1'b0, 1'b0},  // On factory limits
      '{6'h25, 6'h0D, 12'h4A1, 1'b1, 1'b0},  // Just above high
      '{6'h25, 6'h0D, 12'h0CF, 1'b0, 1'b1},  // Just below low
      '{6'h00, 6'h0D, 12'hFFF, 1'b0, 1'b0},  // High check off
      '{6'h25, 6'h00, 12'h000, 1'b0, 1'b0},  // Low check off
      '{6'h3F, 6'h3F, 12'h7E1, 1'b1, 1'b0},  // Top codes
      '{6'h3F, 6'h3F, 12'h3EF, 1'b0, 1'b1},
      '{6'h01, 6'h01, 12'h021, 1'b1, 1'b0}}; // Smallest steps
   logic        core_clk_i, sys_rst_i, wr, nvm, rd, st_cmd, hr_cmd;
   logic        busy, fail, fhi, flo, ef, werr, hrst, scan_en, h_en;
   logic        h_dir, bad_hall, bad_scan, e;
   logic [1:0]  h_sel;
   logic [2:0]  mask;
   logic [7:0]  addr;
   logic [11:0] field, h_ang;
   logic [23:0] wdata, rdata, d;
   logic [30:0] s_in, s_out;
   int          err_total, checks;

   sltf_core #(.TEST_CYCLES(NCYC), .LOGIC_SELF_TEST_SIG(31'h00000000)) i_sltf_core (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(wr),
      .reg_nvm_i(nvm), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_wr_err_o(werr),
      .selftest_cmd_i(st_cmd), .hard_reset_cmd_i(hr_cmd),
      .hard_reset_o(hrst), .scan_en_o(scan_en), .scan_in_o(s_in),
      .scan_out_i(s_out), .hall_test_en_o(h_en), .hall_test_dir_o(h_dir),
      .hall_elem_sel_o(h_sel), .hall_angle_i(h_ang), .field_g_i(field),
      .flag_mask_i(mask), .selftest_busy_o(busy),
      .selftest_fail_flag_o(fail), .field_high_flag_o(fhi),
      .field_low_flag_o(flo), .general_error_flag_o(ef));
   sltf_sense_model i_sltf_sense_model (
      .scan_in_i(s_in), .scan_en_i(scan_en), .hall_en_i(h_en),
      .hall_dir_i(h_dir), .hall_sel_i(h_sel), .bad_hall_i(bad_hall),
      .bad_scan_i(bad_scan), .hall_angle_o(h_ang), .scan_out_o(s_out));

   // Free-running 100 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // Verdict and end of run, shared by the timeouts
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp,
                      input string msg);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk

   // Word with both power-up tests on and no lock
   function automatic logic [23:0] mk(input logic s, input logic h,
                                      input logic [5:0] hi,
                                      input logic [5:0] lo);
      sltf_com_t c;
      c     = '0;
      c.powerup_logic_test_en = 1'b1;
      c.powerup_transducer_test_en = 1'b1;
      c.dst = s;
      c.serial_hard_reset_disable = h;
      c.hi  = hi;
      c.lo  = lo;
      return c;
   endfunction : mk

   // One write; refusal pulse may land in either following cycle
   task automatic wr_reg(input logic [7:0] a, input logic [23:0] v,
                         input logic nv, output logic er);
      @(negedge core_clk_i);
      {wr, addr, wdata, nvm} = {1'b1, a, v, nv};
      @(negedge core_clk_i);
      wr = 1'b0;
      er = werr;
      @(negedge core_clk_i);
      er = er | werr;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [23:0] v);
      @(negedge core_clk_i);
      {rd, addr} = {1'b1, a};
      @(negedge core_clk_i);
      rd = 1'b0;
      v  = rdata;
   endtask : rd_reg

   // Bounded wait for a run, then count its busy cycles
   task automatic run_len();
      int n;
      int w;
      n = 0;
      w = 0;
      while (busy !== 1'b1 && w < 10) begin
         @(negedge core_clk_i);
         w++;
      end
      while (busy === 1'b1 && n < 200) begin
         if (n == 8) begin
            chk({scan_en, h_en}, 2'b11, "tests not parallel");
         end
         @(negedge core_clk_i);
         n++;
      end
      if (w >= 10 || n >= 200) begin
         err_total++;
         $display("unexpected at %0t: self-test wait ran out", $time);
         close_out();
      end
      chk(24'(n), 24'(NCYC), "self-test length");
      @(negedge core_clk_i);
   endtask : run_len

   // Reset held 20 cycles; factory enables start the power-up run
   task automatic do_reset();
      sys_rst_i = 1'b1;
      repeat (20) @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      run_len();
      chk(fail, 1'b0, "power-up test failed");
   endtask : do_reset

   // Serial start pulse, then the expected outcome
   task automatic serial_test(input logic bh, input logic bs);
      {bad_hall, bad_scan} = {bh, bs};
      @(negedge core_clk_i);
      st_cmd = 1'b1;
      @(negedge core_clk_i);
      st_cmd = 1'b0;
      run_len();
      chk(fail, bh | bs, "self-test result");
      chk(ef, bh | bs, "error flag after test");
   endtask : serial_test

   initial begin
      {wr, nvm, rd, st_cmd, hr_cmd, bad_hall, bad_scan} = '0;
      {addr, wdata, mask} = '0;
      field = 12'h200;
      err_total = 0;
      checks = 0;
      do_reset();
      rd_reg(ADDR_COM, d);
      chk(d, COM_RST, "config reset value");
      rd_reg(ADDR_CUSTOMER_STORAGE_WORD, d);
      chk(d, CUSTOMER_STORAGE_WORD_RST, "customer reset value");
      rd_reg(8'h21, d);
      chk(d, 24'h000000, "unmapped read");
      $display("reset test done");
      // Table of field limit cases
      foreach (ROWS[i]) begin
         d = mk(1'b0, 1'b0, ROWS[i].hi, ROWS[i].lo);
         wr_reg(ADDR_COM, d, 1'b0, e);
         field = ROWS[i].fld;
         repeat (3) @(negedge core_clk_i);
         chk(fhi, ROWS[i].eh, "high field flag");
         chk(flo, ROWS[i].el, "low field flag");
         chk(ef, ROWS[i].eh | ROWS[i].el, "general error");
         rd_reg(ADDR_ANG, d);
         e = ROWS[i].eh | ROWS[i].el;
         chk(d[EF_BIT], e, "angle error bit");
      end
      $display("field table done");
      // Masked low flag stays out of the general error
      wr_reg(ADDR_COM, mk(1'b0, 1'b0, 6'h25, 6'h0D), 1'b0, e);
      field = 12'h0CF;
      mask  = 3'h2;
      repeat (3) @(negedge core_clk_i);
      chk({flo, ef}, 2'b10, "masked flag");
      mask  = 3'h0;
      field = 12'h200;
      repeat (3) @(negedge core_clk_i);
      chk({flo, ef}, 2'b00, "flags clear");
      $display("mask test done");
      // Serial self-tests, faults injected one at a time
      serial_test(1'b1, 1'b0);
      serial_test(1'b0, 1'b1);
      serial_test(1'b0, 1'b0);
      wr_reg(ADDR_COM, mk(1'b1, 1'b1, 6'h25, 6'h0D), 1'b0, e);
      st_cmd = 1'b1;
      hr_cmd = 1'b1;
      @(negedge core_clk_i);
      {st_cmd, hr_cmd} = 2'b00;
      e = hrst;
      @(negedge core_clk_i);
      chk({busy, e | hrst}, 2'b00, "disabled commands acted");
      wr_reg(ADDR_COM, mk(1'b0, 1'b0, 6'h25, 6'h0D), 1'b0, e);
      hr_cmd = 1'b1;
      @(negedge core_clk_i);
      hr_cmd = 1'b0;
      e = hrst;
      @(negedge core_clk_i);
      chk(e | hrst, 1'b1, "hard reset missing");
      $display("serial command test done");
      // Nonvolatile lock: shadow still writable
      wr_reg(ADDR_CUSTOMER_STORAGE_WORD, 24'hA5C3F0, 1'b1, e);
      chk(e, 1'b0, "unlocked store write refused");
      d = mk(1'b0, 1'b0, 6'h25, 6'h0D);
      wr_reg(ADDR_COM, {LOCK_NVM, d[19:0]}, 1'b1, e);
      wr_reg(ADDR_CUSTOMER_STORAGE_WORD, 24'h123456, 1'b1, e);
      chk(e, 1'b1, "locked store write taken");
      wr_reg(ADDR_CUSTOMER_STORAGE_WORD, 24'h5A5A5A, 1'b0, e);
      chk(e, 1'b0, "shadow write refused");
      rd_reg(ADDR_CUSTOMER_STORAGE_WORD, d);
      chk(d, 24'h5A5A5A, "shadow readback");
      wr_reg(ADDR_COM, {LOCK_ALL, d[19:0]}, 1'b1, e);
      chk(e, 1'b1, "lock field changed");
      $display("store lock test done");
      // Second reset, then the full lock
      do_reset();
      d = mk(1'b0, 1'b0, 6'h25, 6'h0D);
      wr_reg(ADDR_COM, {LOCK_ALL, d[19:0]}, 1'b1, e);
      wr_reg(ADDR_CUSTOMER_STORAGE_WORD, 24'h0F0F0F, 1'b0, e);
      chk(e, 1'b1, "shadow write under full lock");
      wr_reg(ADDR_CUSTOMER_STORAGE_WORD, 24'h0F0F0F, 1'b1, e);
      chk(e, 1'b1, "store write under full lock");
      wr_reg(ADDR_COM, d, 1'b0, e);
      chk(e, 1'b1, "config write under full lock");
      $display("full lock test done");
      close_out();
   end
endmodule : selftest_lock_field_config_test
`default_nettype wire
